// File: fcd_map.vh
`ifndef FCD_MAP_VH
`define FCD_MAP_VH

// Operation codes on i_op
`define FCD_OP_RESET      4'h0
`define FCD_OP_READ       4'h1
`define FCD_OP_AUTOSEL    4'h2
`define FCD_OP_PROGRAM    4'h3
`define FCD_OP_BYP_ENTER  4'h4
`define FCD_OP_BYP_PROG   4'h5
`define FCD_OP_BYP_EXIT   4'h6
`define FCD_OP_PROT_ENTER 4'h7
`define FCD_OP_PROT_EXIT  4'h8
`define FCD_OP_CHIP_ERASE 4'h9
`define FCD_OP_SECT_ERASE 4'ha
`define FCD_OP_SECT_ADD   4'hb
`define FCD_OP_SUSPEND    4'hc
`define FCD_OP_RESUME     4'hd

// Command bytes
`define FCD_CMD_RESET     8'hf0
`define FCD_CMD_UNLOCK1   8'haa
`define FCD_CMD_UNLOCK2   8'h55
`define FCD_CMD_PROGRAM   8'ha0
`define FCD_CMD_BYPASS    8'h20
`define FCD_CMD_AUTOSEL   8'h90
`define FCD_CMD_ZERO      8'h00
`define FCD_CMD_PROT      8'h88
`define FCD_CMD_SETUP     8'h80
`define FCD_CMD_CHIP      8'h10
`define FCD_CMD_SECTOR    8'h30
`define FCD_CMD_SUSPEND   8'hb0
`define FCD_CMD_RESUME    8'h30

// Unlock addresses, low 12 bits
`define FCD_UA1_WORD      12'h555
`define FCD_UA2_WORD      12'h2aa
`define FCD_UA1_BYTE      12'haaa
`define FCD_UA2_BYTE      12'h555

// Autoselect offsets and answers, for the user side
`define FCD_AS_MFR        12'h000
`define FCD_AS_PROT_WORD  12'h002
`define FCD_AS_PROT_BYTE  12'h004
`define FCD_AS_LOCK_WORD  12'h003
`define FCD_AS_LOCK_BYTE  12'h006
`define FCD_AS_LOCKED     8'h81
`define FCD_AS_UNPROT     8'h00
`define FCD_AS_PROTECTED  8'h01

// Address kinds of a sequence step
`define FCD_AK_U1         3'h0
`define FCD_AK_U2         3'h1
`define FCD_AK_USER       3'h2
`define FCD_AK_SECT       3'h3
`define FCD_AK_ANY        3'h4

// Step entry layout
`define FCD_E_W           14
`define FCD_F_LAST        13
`define FCD_F_READ        12
`define FCD_F_AK_HI       11
`define FCD_F_AK_LO       9
`define FCD_F_UDATA       8
`define FCD_F_BYTE_HI     7

// Timing
`define FCD_CLK_NS        10
`define FCD_PHASE_NS      50
`define FCD_PHASE_CYC     ((`FCD_PHASE_NS + `FCD_CLK_NS - 1) / `FCD_CLK_NS)
`define FCD_SE_WIN_NS     50000
`define FCD_SE_WIN_CYC    (`FCD_SE_WIN_NS / `FCD_CLK_NS)
`define FCD_ADD_MARGIN    16'd64

`endif

// File: fcd_tick.v
`timescale 1ns/1ps
`default_nettype none
`include "fcd_map.vh"

module fcd_tick
(
    // Clock and reset
    input  wire       i_clk,
    input  wire       i_rst,
    // Phase enable
    output reg        o_tick
);

    localparam [31:0] LAST_W = `FCD_PHASE_CYC - 1;
    localparam [3:0]  LAST   = LAST_W[3:0];

    reg [3:0] cnt_q;

    always @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            cnt_q  <= 4'h0;
            o_tick <= 1'b0;
        end
        else
        begin
            o_tick <= (cnt_q == LAST);
            cnt_q  <= (cnt_q == LAST) ? 4'h0 : cnt_q + 4'h1;
        end
    end

endmodule
`default_nettype wire

// File: fcd_seq_rom.v
`timescale 1ns/1ps
`default_nettype none
`include "fcd_map.vh"

module fcd_seq_rom
(
    // Clock and reset
    input  wire                    i_clk,
    input  wire                    i_rst,
    // Lookup
    input  wire [3:0]              i_op,
    input  wire [2:0]              i_step,
    output reg  [`FCD_E_W-1:0]     o_entry
);

    wire pre  = (i_op != `FCD_OP_RESET) && (i_op != `FCD_OP_READ)
             && (i_op != `FCD_OP_BYP_PROG) && (i_op != `FCD_OP_BYP_EXIT)
             && (i_op != `FCD_OP_SECT_ADD) && (i_op != `FCD_OP_SUSPEND)
             && (i_op != `FCD_OP_RESUME);
    wire ers  = (i_op == `FCD_OP_CHIP_ERASE) || (i_op == `FCD_OP_SECT_ERASE);
    wire ul1  = pre && ((i_step == 3'd0) || (ers && i_step == 3'd3));
    wire ul2  = pre && ((i_step == 3'd1) || (ers && i_step == 3'd4));

    always @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
            o_entry <= {`FCD_E_W{1'b0}};
        else if (ul1)
            o_entry <= {2'b00, `FCD_AK_U1, 1'b0, `FCD_CMD_UNLOCK1};
        else if (ul2)
            o_entry <= {2'b00, `FCD_AK_U2, 1'b0, `FCD_CMD_UNLOCK2};
        else
        begin
            case ({i_op, i_step})
                {`FCD_OP_RESET, 3'd0}:
                    o_entry <= {2'b10, `FCD_AK_ANY, 1'b0, `FCD_CMD_RESET};
                {`FCD_OP_READ, 3'd0}:
                    o_entry <= {2'b11, `FCD_AK_USER, 1'b0, `FCD_CMD_ZERO};
                {`FCD_OP_AUTOSEL, 3'd2}:
                    o_entry <= {2'b00, `FCD_AK_U1, 1'b0, `FCD_CMD_AUTOSEL};
                {`FCD_OP_AUTOSEL, 3'd3}:
                    o_entry <= {2'b11, `FCD_AK_USER, 1'b0, `FCD_CMD_ZERO};
                {`FCD_OP_PROGRAM, 3'd2}:
                    o_entry <= {2'b00, `FCD_AK_U1, 1'b0, `FCD_CMD_PROGRAM};
                {`FCD_OP_PROGRAM, 3'd3}:
                    o_entry <= {2'b10, `FCD_AK_USER, 1'b1, `FCD_CMD_ZERO};
                {`FCD_OP_BYP_ENTER, 3'd2}:
                    o_entry <= {2'b10, `FCD_AK_U1, 1'b0, `FCD_CMD_BYPASS};
                {`FCD_OP_BYP_PROG, 3'd0}:
                    o_entry <= {2'b00, `FCD_AK_ANY, 1'b0, `FCD_CMD_PROGRAM};
                {`FCD_OP_BYP_PROG, 3'd1}:
                    o_entry <= {2'b10, `FCD_AK_USER, 1'b1, `FCD_CMD_ZERO};
                {`FCD_OP_BYP_EXIT, 3'd0}:
                    o_entry <= {2'b00, `FCD_AK_ANY, 1'b0, `FCD_CMD_AUTOSEL};
                {`FCD_OP_BYP_EXIT, 3'd1}:
                    o_entry <= {2'b10, `FCD_AK_ANY, 1'b0, `FCD_CMD_ZERO};
                {`FCD_OP_PROT_ENTER, 3'd2}:
                    o_entry <= {2'b10, `FCD_AK_U1, 1'b0, `FCD_CMD_PROT};
                {`FCD_OP_PROT_EXIT, 3'd2}:
                    o_entry <= {2'b00, `FCD_AK_U1, 1'b0, `FCD_CMD_AUTOSEL};
                {`FCD_OP_PROT_EXIT, 3'd3}:
                    o_entry <= {2'b10, `FCD_AK_ANY, 1'b0, `FCD_CMD_ZERO};
                {`FCD_OP_CHIP_ERASE, 3'd2}, {`FCD_OP_SECT_ERASE, 3'd2}:
                    o_entry <= {2'b00, `FCD_AK_U1, 1'b0, `FCD_CMD_SETUP};
                {`FCD_OP_CHIP_ERASE, 3'd5}:
                    o_entry <= {2'b10, `FCD_AK_U1, 1'b0, `FCD_CMD_CHIP};
                {`FCD_OP_SECT_ERASE, 3'd5}, {`FCD_OP_SECT_ADD, 3'd0}:
                    o_entry <= {2'b10, `FCD_AK_SECT, 1'b0, `FCD_CMD_SECTOR};
                {`FCD_OP_SUSPEND, 3'd0}:
                    o_entry <= {2'b10, `FCD_AK_SECT, 1'b0, `FCD_CMD_SUSPEND};
                {`FCD_OP_RESUME, 3'd0}:
                    o_entry <= {2'b10, `FCD_AK_SECT, 1'b0, `FCD_CMD_RESUME};
                default:
                    o_entry <= {`FCD_E_W{1'b0}};
            endcase
        end
    end

endmodule
`default_nettype wire

// File: fcd_host.v
`timescale 1ns/1ps
`default_nettype none
`include "fcd_map.vh"

module fcd_host
#(
    parameter WIN_CYC = `FCD_SE_WIN_CYC
)
(
    // Clock and reset
    input  wire        i_clk,
    input  wire        i_rst,
    // User request
    input  wire        i_req,
    input  wire [3:0]  i_op,
    input  wire [19:0] i_addr,
    input  wire [15:0] i_wdata,
    input  wire        i_byte_mode,
    input  wire        i_erase_done,
    // User answer
    output reg         o_ready,
    output reg         o_done,
    output reg         o_refused,
    output reg  [15:0] o_rdata,
    // Mode view
    output reg         o_bypass,
    output reg         o_autosel,
    output reg         o_protreg,
    output reg         o_erasing,
    output reg         o_suspended,
    // Flash pins
    output reg  [19:0] o_addr,
    output reg  [15:0] o_dq,
    output reg         o_dq_oe,
    input  wire [15:0] i_dq,
    output reg         o_ce_n,
    output reg         o_we_n,
    output reg         o_oe_n,
    output reg         o_byte_n
);

    localparam [2:0] S_IDLE  = 3'h0;
    localparam [2:0] S_LOAD  = 3'h1;
    localparam [2:0] S_SETUP = 3'h2;
    localparam [2:0] S_PULSE = 3'h3;
    localparam [2:0] S_HOLD  = 3'h4;
    localparam [2:0] S_GAP   = 3'h5;
    localparam [2:0] S_ROM   = 3'h6;

    localparam [15:0] WIN = WIN_CYC[15:0];

    reg  [2:0]            st_q;
    reg  [3:0]            op_q;
    reg  [2:0]            step_q;
    reg  [19:0]           ua_q;
    reg  [15:0]           wd_q;
    reg                   last_q;
    reg                   rd_q;
    reg  [15:0]           win_q;
    reg                   chip_q;
    reg  [15:0]           dq_s1_q;
    reg  [15:0]           dq_s2_q;
    reg                   allow;
    reg  [19:0]           map_addr;
    wire                  tick;
    wire [`FCD_E_W-1:0]   entry;
    wire [2:0]            ak = entry[`FCD_F_AK_HI:`FCD_F_AK_LO];
    wire                  win_open = (win_q > `FCD_ADD_MARGIN);

    fcd_tick u_tick
    (
        .i_clk  (i_clk),
        .i_rst  (i_rst),
        .o_tick (tick)
    );

    fcd_seq_rom u_rom
    (
        .i_clk   (i_clk),
        .i_rst   (i_rst),
        .i_op    (op_q),
        .i_step  (step_q),
        .o_entry (entry)
    );

    // Which operations the current device mode will take
    always @*
    begin
        allow = 1'b0;
        if (o_bypass)
            allow = (i_op == `FCD_OP_BYP_PROG) || (i_op == `FCD_OP_BYP_EXIT);
        else if (o_autosel)
            allow = (i_op == `FCD_OP_READ) || (i_op == `FCD_OP_RESET);
        else if (o_erasing && !o_suspended)
            allow = (i_op == `FCD_OP_READ)
                 || ((i_op == `FCD_OP_SUSPEND) && !chip_q)
                 || ((i_op == `FCD_OP_SECT_ADD) && win_open);
        else if (o_suspended)
            allow = (i_op == `FCD_OP_READ) || (i_op == `FCD_OP_PROGRAM)
                 || (i_op == `FCD_OP_AUTOSEL) || (i_op == `FCD_OP_RESET)
                 || (i_op == `FCD_OP_RESUME);
        else
            allow = (i_op <= `FCD_OP_SECT_ERASE) && (i_op != `FCD_OP_BYP_PROG)
                 && (i_op != `FCD_OP_BYP_EXIT);
    end

    // Step address; upper bits are free for the device, so the user's go out, except on any-address steps, which drive all zero
    always @*
    begin
        case (ak)
            `FCD_AK_U1:
                map_addr = {ua_q[19:12], i_byte_mode ? `FCD_UA1_BYTE : `FCD_UA1_WORD};
            `FCD_AK_U2:
                map_addr = {ua_q[19:12], i_byte_mode ? `FCD_UA2_BYTE : `FCD_UA2_WORD};
            `FCD_AK_USER:
                map_addr = ua_q;
            `FCD_AK_SECT:
                map_addr = {ua_q[19:12], 12'h000};
            default:
                map_addr = 20'h00000;
        endcase
    end

    // Data pins pass two flops before use
    always @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            dq_s1_q <= 16'h0000;
            dq_s2_q <= 16'h0000;
        end
        else
        begin
            dq_s1_q <= i_dq;
            dq_s2_q <= dq_s1_q;
        end
    end

    // Bus cycle sequencer
    always @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            st_q      <= S_IDLE;
            op_q      <= `FCD_OP_RESET;
            step_q    <= 3'h0;
            ua_q      <= 20'h00000;
            wd_q      <= 16'h0000;
            last_q    <= 1'b0;
            rd_q      <= 1'b0;
            o_ready   <= 1'b0;
            o_done    <= 1'b0;
            o_refused <= 1'b0;
            o_rdata   <= 16'h0000;
            o_addr    <= 20'h00000;
            o_dq      <= 16'h0000;
            o_dq_oe   <= 1'b0;
            o_ce_n    <= 1'b1;
            o_we_n    <= 1'b1;
            o_oe_n    <= 1'b1;
            o_byte_n  <= 1'b1;
        end
        else
        begin
            o_done    <= 1'b0;
            o_refused <= 1'b0;
            o_byte_n  <= ~i_byte_mode;
            case (st_q)
                S_IDLE:
                begin
                    o_ready <= 1'b1;
                    if (o_ready && i_req)
                    begin
                        o_ready <= 1'b0;
                        if (allow)
                        begin
                            op_q   <= i_op;
                            ua_q   <= i_addr;
                            wd_q   <= i_wdata;
                            step_q <= 3'h0;
                            st_q   <= S_ROM;
                        end
                        else
                        begin
                            o_refused <= 1'b1;
                        end
                    end
                end
                S_ROM:
                    st_q <= S_LOAD;
                S_LOAD:
                begin
                    // Address and enables first; strobe falls later
                    last_q  <= entry[`FCD_F_LAST];
                    rd_q    <= entry[`FCD_F_READ];
                    o_addr  <= map_addr;
                    o_ce_n  <= 1'b0;
                    o_oe_n  <= ~entry[`FCD_F_READ];
                    o_dq_oe <= ~entry[`FCD_F_READ];
                    o_dq    <= entry[`FCD_F_UDATA] ? wd_q
                             : {8'h00, entry[`FCD_F_BYTE_HI:0]};
                    if (tick)
                        st_q <= S_SETUP;
                end
                S_SETUP:
                begin
                    if (tick)
                    begin
                        o_we_n <= rd_q;
                        st_q   <= S_PULSE;
                    end
                end
                S_PULSE:
                begin
                    if (tick)
                    begin
                        // Write strobe rises while chip enable stays low
                        o_we_n <= 1'b1;
                        st_q   <= S_HOLD;
                    end
                end
                S_HOLD:
                begin
                    if (tick)
                    begin
                        if (rd_q)
                            o_rdata <= dq_s2_q;
                        o_ce_n  <= 1'b1;
                        o_oe_n  <= 1'b1;
                        o_dq_oe <= 1'b0;
                        st_q    <= S_GAP;
                    end
                end
                S_GAP:
                begin
                    if (tick)
                    begin
                        if (last_q)
                        begin
                            o_done <= 1'b1;
                            st_q   <= S_IDLE;
                        end
                        else
                        begin
                            step_q <= step_q + 3'h1;
                            st_q   <= S_ROM;
                        end
                    end
                end
                default:
                    st_q <= S_IDLE;
            endcase
        end
    end

    // Mirror of the device mode; a finishing command beats erase-done
    always @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_bypass    <= 1'b0;
            o_autosel   <= 1'b0;
            o_protreg   <= 1'b0;
            o_erasing   <= 1'b0;
            o_suspended <= 1'b0;
            chip_q      <= 1'b0;
            win_q       <= 16'h0000;
        end
        else
        begin
            if (win_q != 16'h0000)
                win_q <= win_q - 16'h0001;
            if (i_erase_done)
            begin
                o_erasing   <= 1'b0;
                o_suspended <= 1'b0;
                chip_q      <= 1'b0;
            end
            if (st_q == S_GAP && tick && last_q)
            begin
                case (op_q)
                    `FCD_OP_RESET:      o_autosel <= 1'b0;
                    `FCD_OP_AUTOSEL:    o_autosel <= 1'b1;
                    `FCD_OP_BYP_ENTER:  o_bypass  <= 1'b1;
                    `FCD_OP_BYP_EXIT:   o_bypass  <= 1'b0;
                    `FCD_OP_PROT_ENTER: o_protreg <= 1'b1;
                    `FCD_OP_PROT_EXIT:  o_protreg <= 1'b0;
                    `FCD_OP_CHIP_ERASE:
                    begin
                        o_erasing <= 1'b1;
                        chip_q    <= 1'b1;
                    end
                    `FCD_OP_SECT_ERASE, `FCD_OP_SECT_ADD:
                    begin
                        // Window restarts at the end of the gap phase, two phases after the final write strobe rise
                        o_erasing <= 1'b1;
                        win_q     <= WIN;
                    end
                    `FCD_OP_SUSPEND:
                    begin
                        o_erasing   <= 1'b1;
                        o_suspended <= 1'b1;
                        win_q       <= 16'h0000;
                    end
                    `FCD_OP_RESUME:
                    begin
                        o_erasing   <= 1'b1;
                        o_suspended <= 1'b0;
                    end
                    default:
                        o_bypass <= o_bypass;
                endcase
            end
        end
    end

endmodule
`default_nettype wire

// File: fcd_host_sva.sv
`timescale 1ns/1ps
`default_nettype none
`include "fcd_map.vh"

module fcd_host_sva
(
    // Clock and reset
    input wire logic        i_clk,
    input wire logic        i_rst,
    // User side
    input wire logic        i_req,
    input wire logic [3:0]  i_op,
    input wire logic        i_byte_mode,
    input wire logic        o_ready,
    input wire logic        o_refused,
    input wire logic        o_bypass,
    input wire logic        o_erasing,
    input wire logic        o_suspended,
    // Flash pins
    input wire logic [19:0] o_addr,
    input wire logic [15:0] o_dq,
    input wire logic        o_dq_oe,
    input wire logic        o_ce_n,
    input wire logic        o_we_n,
    input wire logic        o_oe_n,
    input wire logic        o_byte_n
);
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_rst);

    wire tk = o_ready && i_req;

    property p_take;
        tk |=> !o_ready;
    endproperty
    property p_wr;
        !o_we_n |-> !o_ce_n && o_oe_n && o_dq_oe;
    endproperty
    property p_we_len;
        $fell(o_we_n) |-> !o_we_n [*5] ##1 o_we_n;
    endproperty
    property p_hold;
        !o_we_n |-> $stable(o_addr) && $stable(o_dq);
    endproperty
    property p_byte;
        o_byte_n == !$past(i_byte_mode);
    endproperty
    property p_byp;
        tk && o_bypass && i_op == `FCD_OP_PROGRAM |=> o_refused;
    endproperty
    property p_susp;
        tk && !o_erasing && i_op == `FCD_OP_SUSPEND |=> o_refused;
    endproperty
    property p_res;
        tk && !o_suspended && i_op == `FCD_OP_RESUME |=> o_refused;
    endproperty
    property p_quiet;
        o_refused |-> o_ce_n ##1 o_ready && o_ce_n;
    endproperty

    a_take: assert property (p_take)
        else $error("ready held after take");
    a_wr: assert property (p_wr)
        else $error("write strobe outside write cycle");
    a_we_len: assert property (p_we_len)
        else $error("write pulse length wrong");
    a_hold: assert property (p_hold)
        else $error("address or data moved in write pulse");
    a_byte: assert property (p_byte)
        else $error("byte pin does not follow mode");
    a_byp: assert property (p_byp)
        else $error("program accepted in bypass");
    a_susp: assert property (p_susp)
        else $error("suspend accepted while idle");
    a_res: assert property (p_res)
        else $error("resume accepted while not suspended");
    a_quiet: assert property (p_quiet)
        else $error("refusal touched the pins");

    c_susp: cover property (tk && i_op == `FCD_OP_SUSPEND && o_erasing);
    c_ref: cover property (o_refused && o_bypass);
    c_byte: cover property (tk && i_byte_mode);
endmodule
`default_nettype wire

// File: fcd_mdl.sv
`timescale 1ns/1ps
`default_nettype none

module fcd_mdl
#(
    parameter logic [15:0] MFR_ID = 16'h005c, // Arbitrary value
    parameter bit          LOCKED = 1'b1
)
(
    // Flash pins
    input  wire logic [19:0] i_addr,
    input  wire logic [15:0] i_dq,
    input  wire logic        i_ce_n,
    input  wire logic        i_we_n,
    input  wire logic        i_oe_n,
    input  wire logic        i_byte_n,
    output wire logic [15:0] o_dq
);
    logic [15:0] mem [0:4095];
    logic [19:0] la [0:255];
    logic [15:0] ld [0:255];
    int          nw = 0;
    logic [19:0] lat_a;
    logic        act = 0, asel = 0, pg = 0, byp = 0;
    logic [2:0]  st = 0;
    logic [15:0] rv;

    initial
    begin
        for (int i = 0; i < 4096; i++)
            mem[i] = {4'ha, i[11:0]};
    end

    task automatic wr(input logic [19:0] a, input logic [15:0] d);
        logic [10:0] u1, u2;
        u1 = i_byte_n ? 11'h555 : 11'h2aa;
        u2 = i_byte_n ? 11'h2aa : 11'h555;
        la[nw] = a;
        ld[nw] = d;
        nw++;
        if (pg)
        begin
            mem[a[11:0]] = d;
            pg = 0;
        end
        else if (byp)
        begin
            pg = (d[7:0] == 8'ha0);
            if (st == 7 && d[7:0] == 8'h00)
                byp = 0;
            st = (d[7:0] == 8'h90) ? 3'd7 : 3'd0;
        end
        else if (d[7:0] == 8'hf0)
            asel = 0;
        else if (st == 0 && a[10:0] == u1 && d[7:0] == 8'haa)
            st = 1;
        else if (st == 1 && a[10:0] == u2 && d[7:0] == 8'h55)
            st = 2;
        else if (st == 2)
        begin
            asel = asel | (d[7:0] == 8'h90);
            pg = (d[7:0] == 8'ha0);
            byp = (d[7:0] == 8'h20);
            st = 0;
        end
        else
        begin
            if (d[7:0] == 8'h00)
                asel = 0;
            st = 0;
        end
    endtask

    // Address at the later fall, data at the earlier rise
    always @(negedge i_we_n or negedge i_ce_n)
        if (!i_we_n && !i_ce_n)
        begin
            lat_a = i_addr;
            act = 1;
        end
    always @(posedge i_we_n or posedge i_ce_n)
        if (act)
        begin
            act = 0;
            wr(lat_a, i_dq);
        end

    always_comb
    begin
        rv = mem[i_addr[11:0]];
        if (asel && i_addr[7:0] == 8'h00)
            rv = MFR_ID;
        if (asel && i_addr[7:0] == (i_byte_n ? 8'h03 : 8'h06))
            rv = LOCKED ? 16'h0081 : 16'h0001;
        if (asel && i_addr[7:0] == (i_byte_n ? 8'h02 : 8'h04))
            rv = {15'h0, ^i_addr[19:12]};
    end
    // No pull on the bus: released lines show the inverse
    assign o_dq = (!i_ce_n && !i_oe_n) ? rv : ~rv;
endmodule
`default_nettype wire

// File: tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "fcd_map.vh"

module tb;
    localparam logic [15:0] MFR = 16'h005c; // Arbitrary value
    logic        i_clk = 0, i_rst = 1, i_req = 0;
    logic [3:0]  i_op = 0;
    logic [19:0] i_addr = 0;
    logic [15:0] i_wdata = 0;
    logic        i_byte_mode = 0;
    logic        i_erase_done = 0;
    wire         o_ready, o_done, o_refused, o_bypass, o_autosel, o_protreg;
    wire         o_erasing, o_suspended, o_dq_oe, o_ce_n, o_we_n, o_oe_n, o_byte_n;
    wire  [15:0] o_rdata, o_dq, fdq, i_dq;
    wire  [19:0] o_addr;
    int          error_cnt = 0, n_compared = 0, k = 0;
    logic [19:0] a, a2;
    logic [15:0] d;
    bit          bm = 0;

    assign i_dq = o_dq_oe ? o_dq : fdq;
    always #5 i_clk = ~i_clk;

    fcd_host #(.WIN_CYC(200)) fcd_host_i (.i_clk, .i_rst, .i_req, .i_op, .i_addr, .i_wdata,
        .i_byte_mode, .i_erase_done, .o_ready, .o_done, .o_refused, .o_rdata, .o_bypass,
        .o_autosel, .o_protreg, .o_erasing, .o_suspended, .o_addr, .o_dq, .o_dq_oe, .i_dq,
        .o_ce_n, .o_we_n, .o_oe_n, .o_byte_n);
    fcd_mdl #(.MFR_ID(MFR)) fcd_mdl_i (.i_addr(o_addr), .i_dq(i_dq), .i_ce_n(o_ce_n),
        .i_we_n(o_we_n), .i_oe_n(o_oe_n), .i_byte_n(o_byte_n), .o_dq(fdq));

    task automatic results;
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic chk(input logic [35:0] g, input logic [35:0] e);
        n_compared++;
        if (g !== e)
        begin
            error_cnt++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    function automatic logic [15:0] as_exp(input int j, input logic [19:0] ad);
        return j == 0 ? MFR : j == 1 ? {15'h0, ^ad[19:12]} : {8'h00, `FCD_AS_LOCKED};
    endfunction

    // One logged write cycle; any skips the address
    task automatic expw(input logic [19:0] ea, input logic [15:0] ed, input bit any);
        chk({any ? 20'h0 : fcd_mdl_i.la[k], fcd_mdl_i.ld[k]}, {any ? 20'h0 : ea, ed});
        k++;
    endtask
    task automatic expc(input logic [19:0] ba, input logic [7:0] c);
        expw({ba[19:12], bm ? 12'haaa : 12'h555}, {8'h00, c}, 0);
    endtask
    task automatic expu(input logic [19:0] ba);
        expc(ba, 8'haa);
        expw({ba[19:12], bm ? 12'h555 : 12'h2aa}, 16'h0055, 0);
    endtask

    task automatic run(input logic [3:0] op, input logic [19:0] ad, input logic [15:0] wd,
                       input bit rf);
        int n;
        chk(fcd_mdl_i.nw, k);
        n = 0;
        while (o_ready !== 1'b1 && n < 100)
        begin
            @(negedge i_clk);
            n++;
        end
        i_req = 1;
        i_op = op;
        i_addr = ad;
        i_wdata = wd;
        @(negedge i_clk);
        i_req = 0;
        n = 0;
        // Bounded wait; a hang shows as neither pulse
        while (o_done !== 1'b1 && o_refused !== 1'b1 && n < 400)
        begin
            @(negedge i_clk);
            n++;
        end
        chk({o_done, o_refused}, {!rf, rf});
        @(negedge i_clk);
    endtask

    task automatic edone;
        i_erase_done = 1;
        repeat (2) @(negedge i_clk);
        i_erase_done = 0;
        chk({o_erasing, o_suspended}, 0);
    endtask

    initial
    begin
        #500000;
        error_cnt++;
        results();
    end

    initial
    begin
        void'($urandom(32'h20afde7a));
        repeat (20) @(negedge i_clk);
        chk({o_ce_n, o_we_n, o_oe_n, o_dq_oe, o_ready}, 5'b11100);
        i_rst = 0;
        repeat (2) @(negedge i_clk);
        chk({o_ce_n, o_we_n, o_oe_n, o_dq_oe, o_ready}, 5'b11101);
        repeat (6)
        begin
            a = 20'($urandom);
            run(`FCD_OP_READ, a, 0, 0);
            chk(o_rdata, {4'ha, a[11:0]});
        end
        for (int m = 0; m < 2; m++)
        begin
            bm = m[0];
            i_byte_mode = bm;
            repeat (3) @(negedge i_clk);
            a = 20'($urandom);
            d = 16'($urandom);
            run(`FCD_OP_PROGRAM, a, d, 0);
            expu(a);
            expc(a, 8'ha0);
            expw(a, d, 0);
            run(`FCD_OP_READ, a, 0, 0);
            chk(o_rdata, d);
            for (int j = 0; j < 3; j++)
            begin
                a2 = {a[19:12], 4'h0, j == 0 ? 8'h00 : j == 1 ? (bm ? 8'h04 : 8'h02) :
                      (bm ? 8'h06 : 8'h03)};
                run(`FCD_OP_AUTOSEL, a2, 0, 0);
                expu(a2);
                expc(a2, 8'h90);
                chk({o_autosel, o_rdata}, {1'b1, as_exp(j, a2)});
                run(`FCD_OP_PROGRAM, a, d, 1);
                run(`FCD_OP_RESET, a, 0, 0);
                expw(0, 16'h00f0, 1);
                chk(o_autosel, 0);
            end
        end
        a = 20'($urandom);
        d = 16'($urandom);
        run(`FCD_OP_BYP_ENTER, a, 0, 0);
        expu(a);
        expc(a, 8'h20);
        chk(o_bypass, 1);
        run(`FCD_OP_PROGRAM, a, d, 1);
        run(`FCD_OP_BYP_PROG, a, d, 0);
        expw(0, 16'h00a0, 1);
        expw(a, d, 0);
        run(`FCD_OP_BYP_EXIT, a, 0, 0);
        expw(0, 16'h0090, 1);
        expw(0, 16'h0000, 1);
        run(`FCD_OP_READ, a, 0, 0);
        chk({o_bypass, o_rdata}, {1'b0, d});
        run(`FCD_OP_PROT_ENTER, a, 0, 0);
        expu(a);
        expc(a, 8'h88);
        chk(o_protreg, 1);
        run(`FCD_OP_PROT_EXIT, a, 0, 0);
        expu(a);
        expc(a, 8'h90);
        expw(0, 16'h0000, 1);
        chk(o_protreg, 0);
        for (int c = 0; c < 2; c++)
        begin
            run(c ? `FCD_OP_SECT_ERASE : `FCD_OP_CHIP_ERASE, a, 0, 0);
            expu(a);
            expc(a, 8'h80);
            expu(a);
            if (c)
                expw({a[19:12], 12'h000}, 16'h0030, 0);
            else
                expc(a, 8'h10);
            chk(o_erasing, 1);
            if (!c)
            begin
                run(`FCD_OP_SUSPEND, a, 0, 1);
                edone();
            end
        end
        a2 = a ^ 20'h01000;
        run(`FCD_OP_SECT_ADD, a2, 0, 0);
        expw({a2[19:12], 12'h000}, 16'h0030, 0);
        run(`FCD_OP_SUSPEND, a, 0, 0);
        expw({a[19:12], 12'h000}, 16'h00b0, 0);
        chk(o_suspended, 1);
        run(`FCD_OP_PROGRAM, a ^ 20'h04000, d, 0);
        expu(a ^ 20'h04000);
        expc(a ^ 20'h04000, 8'ha0);
        expw(a ^ 20'h04000, d, 0);
        run(`FCD_OP_RESUME, a, 0, 0);
        expw({a[19:12], 12'h000}, 16'h0030, 0);
        chk(o_suspended, 0);
        edone();
        run(`FCD_OP_RESUME, a, 0, 1);
        run(`FCD_OP_SUSPEND, a, 0, 1);
        run(`FCD_OP_SECT_ERASE, a, 0, 0);
        k += 6;
        repeat (150) @(negedge i_clk);
        run(`FCD_OP_SECT_ADD, a2, 0, 1);
        chk(fcd_mdl_i.nw, k);
        results();
    end
endmodule

bind fcd_host fcd_host_sva fcd_host_sva_i (.i_clk, .i_rst, .i_req, .i_op, .i_byte_mode,
    .o_ready, .o_refused, .o_bypass, .o_erasing, .o_suspended, .o_addr, .o_dq, .o_dq_oe,
    .o_ce_n, .o_we_n, .o_oe_n, .o_byte_n);
`default_nettype wire
